// File: dv/csl_far_model.sv
// far-side model: two comparators and the port output stage of both pins
`timescale 1ns/1ps

module csl_far_model (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_vin_p1,
	input wire logic [7:0] i_vin_n1,
	input wire logic [7:0] i_vin_p2,
	input wire logic [7:0] i_vin_n2,
	input wire logic [3:0] i_port_cfg,
	input wire logic i_pin1,
	input wire logic i_pin1_oe,
	input wire logic i_pin2,
	input wire logic i_pin2_oe,
	output logic o_cmp1_result,
	output logic o_cmp2_result,
	output logic o_en1,
	output logic o_en2,
	output logic o_dir1,
	output logic o_dir2,
	output logic o_pad1,
	output logic o_pad2
);
	logic last1_q = 1'b0;
	logic last2_q = 1'b0;
	// =============================================================
	// comparators: analog, so no clock
	assign o_cmp1_result = i_vin_p1 > i_vin_n1;
	assign o_cmp2_result = i_vin_p2 > i_vin_n2;
	// =============================================================
	// port setup: drive enable and direction of both pins come straight from i_port_cfg
	assign o_en1 = i_port_cfg[0];
	assign o_en2 = i_port_cfg[1];
	assign o_dir1 = i_port_cfg[2];
	assign o_dir2 = i_port_cfg[3];
	// =============================================================
	// undriven pad shows the inverse, so a stale value never passes
	always_ff @(posedge i_clk_sys) begin
		last1_q <= o_pad1;
		last2_q <= o_pad2;
	end
	assign o_pad1 = i_pin1_oe ? i_pin1 : ~last1_q;
	assign o_pad2 = i_pin2_oe ? i_pin2 : ~last2_q;
endmodule : csl_far_model

// File: dv/test_csl_top.sv
// self-checking bench of the comparator latch block
`timescale 1ns/1ps
`include "csl_map.svh"

module test_csl_top;
	import csl_pkg::*;
	logic i_clk_sys = 0;
	logic i_reset = 1;
	logic i_wr = 0;
	logic i_rd = 0;
	csl_addr_t i_addr = '0;
	csl_data_t i_wdata = '0;
	csl_data_t o_rdata;
	csl_data_t d;
	logic [7:0] vp1 = 0, vn1 = 0, vp2 = 0, vn2 = 0;
	logic [3:0] cfg = 4'hC;
	logic [3:0] cfg_e = 4'hC;
	logic c1, c2, e1, e2, r1, r2, p1, p1_oe, p2, p2_oe, fre;
	logic c1e = 0, c2e = 0, q = 0;
	logic [7:0] ctl = 0;
	int fails = 0;
	int n_tests = 0;

	csl_far_model far (.i_clk_sys(i_clk_sys), .i_vin_p1(vp1),
		.i_vin_n1(vn1), .i_vin_p2(vp2), .i_vin_n2(vn2),
		.i_port_cfg(cfg), .i_pin1(p1), .i_pin1_oe(p1_oe), .i_pin2(p2),
		.i_pin2_oe(p2_oe), .o_cmp1_result(c1), .o_cmp2_result(c2),
		.o_en1(e1), .o_en2(e2), .o_dir1(r1), .o_dir2(r2), .o_pad1(),
		.o_pad2());
	csl_top dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_cmp1_result(c1), .i_cmp2_result(c2),
		.i_cmp1_pin_drive_enable(e1), .i_cmp2_pin_drive_enable(e2),
		.i_cmp1_port_direction(r1), .i_cmp2_port_direction(r2),
		.o_cmp1_pin(p1), .o_cmp1_pin_oe(p1_oe), .o_cmp2_pin(p2),
		.o_cmp2_pin_oe(p2_oe), .o_fixed_ref_enable(fre));

	initial begin
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// =============================================================
	// helpers
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// reset wins over set
	function logic step(input logic qo, input logic s, input logic r);
		return r ? 1'b0 : (s ? 1'b1 : qo);
	endfunction : step

	task wr(input csl_addr_t a, input csl_data_t v);
		@(posedge i_clk_sys);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk_sys);
		i_wr <= 0;
		if (a == `CSL_ADDR_LATCH_CONTROL) begin
			ctl = v & 8'hF1;
			q = step(q, (c1e & ctl[5]) | v[3], (c2e & ctl[4]) | v[2]);
			q = step(q, c1e & ctl[5], c2e & ctl[4]);
		end
	endtask : wr

	task rd(input csl_addr_t a, output csl_data_t v);
		@(posedge i_clk_sys);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 0;
		#1 v = o_rdata;
	endtask : rd

	task drive(input logic [7:0] a1, b1, a2, b2);
		@(posedge i_clk_sys);
		vp1 <= a1;
		vn1 <= b1;
		vp2 <= a2;
		vn2 <= b2;
		cfg_e = 4'($urandom);
		cfg <= cfg_e;
		c1e = a1 > b1;
		c2e = a2 > b2;
		q = step(q, c1e & ctl[5], c2e & ctl[4]);
	endtask : drive

	task pins;
		@(posedge i_clk_sys);
		#1;
		chk({5'h0, fre, p2, p1}, {5'h0, ctl[0], ctl[7] ? ~q : c2e,
			ctl[6] ? q : c1e});
		chk({6'h0, p2_oe, p1_oe}, {6'h0, cfg_e[1] & ~cfg_e[3],
			cfg_e[0] & ~cfg_e[2]});
	endtask : pins

	// =============================================================
	// tests
	initial begin
		void'($urandom(8255));
		repeat (3) @(posedge i_clk_sys);
		i_reset <= 0;
		rd(`CSL_ADDR_LATCH_CONTROL, d);
		chk(d, `CSL_RST_LATCH_CONTROL);
		drive(8'h09, 8'h01, 8'h01, 8'h09);
		pins;
		$display("reset test done");
		wr(4'h0, 8'hCA);
		pins;
		rd(4'h0, d);
		chk(d, 8'hC0);
		wr(4'h0, 8'hC0);
		pins;
		wr(4'h0, 8'hC4);
		pins;
		wr(4'h0, 8'hC8);
		wr(4'h0, 8'hCC);
		pins;
		$display("pulse test done");
		wr(4'h0, 8'h80);
		pins;
		wr(4'h0, 8'h60);
		pins;
		drive(8'h01, 8'h09, 8'h01, 8'h09);
		pins;
		wr(4'h0, 8'hF0);
		drive(8'h09, 8'h01, 8'h09, 8'h01);
		pins;
		drive(8'h09, 8'h01, 8'h01, 8'h09);
		pins;
		wr(4'h0, 8'hF4);
		pins;
		wr(4'h0, 8'h14);
		pins;
		$display("comparator path test done");
		repeat (80) begin
			drive(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
			pins;
			wr(4'h0, 8'($urandom));
			pins;
			rd(4'h0, d);
			chk(d, ctl);
		end
		$display("random test done");
		wr(4'hF, 8'hFF);
		rd(4'h0, d);
		chk(d, ctl);
		rd(4'h9, d);
		chk(d, 8'h00);
		repeat (8) @(posedge i_clk_sys);
		rd(`CSL_ADDR_LATCH_STATUS, d);
		chk(d, {5'h0, q, c2e, c1e});
		$display("map test done");
		wr(4'h0, 8'hC9);
		@(posedge i_clk_sys);
		i_reset <= 1;
		@(posedge i_clk_sys);
		i_reset <= 0;
		ctl = 0;
		q = 0;
		rd(4'h0, d);
		chk(d, 8'h00);
		pins;
		$display("second reset test done");
		give_verdict;
	end

	initial begin
		#200000;
		fails++;
		give_verdict;
	end
endmodule : test_csl_top

// File: src/csl_map.svh
// register offsets, field positions and reset values of the latch block
`ifndef CSL_MAP_SVH
`define CSL_MAP_SVH

// =============================================================
// register offsets
`define CSL_ADDR_LATCH_CONTROL 4'h0
`define CSL_ADDR_LATCH_STATUS 4'h1

// =============================================================
// latch_control fields
`define CSL_BIT_ROUTE_SEL_HI 7
`define CSL_BIT_ROUTE_SEL_LO 6
`define CSL_BIT_CMP1_SET_ENABLE 5
`define CSL_BIT_CMP2_RESET_ENABLE 4
`define CSL_BIT_SET_PULSE 3
`define CSL_BIT_RESET_PULSE 2
`define CSL_BIT_UNUSED 1
`define CSL_BIT_FIXED_REF_ENABLE 0

// =============================================================
// latch_status fields
`define CSL_BIT_STAT_CMP1 0
`define CSL_BIT_STAT_CMP2 1
`define CSL_BIT_STAT_LATCH_Q 2

// =============================================================
// reset values
`define CSL_RST_LATCH_CONTROL 8'h00
`define CSL_RST_ROUTE_SEL 2'h0
`define CSL_RST_RDATA 8'h00

`endif

// File: src/csl_pin_mux.sv
// output multiplexers and drive enables of the two comparator pins
`timescale 1ns/1ps

module csl_pin_mux (
	input wire csl_pkg::csl_route_e i_route_sel,
	input wire logic i_cmp1_result,
	input wire logic i_cmp2_result,
	input wire logic i_latch_q,
	input wire logic i_latch_q_n,
	input wire logic i_cmp1_pin_drive_enable,
	input wire logic i_cmp2_pin_drive_enable,
	input wire logic i_cmp1_port_direction,
	input wire logic i_cmp2_port_direction,
	output logic o_cmp1_pin,
	output logic o_cmp1_pin_oe,
	output logic o_cmp2_pin,
	output logic o_cmp2_pin_oe
);
	import csl_pkg::*;

	// =============================================================
	// routing
	// comparator power state is deliberately not an input here
	assign o_cmp1_pin = i_route_sel[0] ? i_latch_q : i_cmp1_result;
	assign o_cmp2_pin = i_route_sel[1] ? i_latch_q_n : i_cmp2_result;

	// =============================================================
	// drive enables
	assign o_cmp1_pin_oe = i_cmp1_pin_drive_enable && !i_cmp1_port_direction;
	assign o_cmp2_pin_oe = i_cmp2_pin_drive_enable && !i_cmp2_port_direction;

endmodule : csl_pin_mux

// File: src/csl_pkg.sv
// types shared by the comparator latch block
package csl_pkg;

	// =============================================================
	// bus types
	typedef logic [3:0] csl_addr_t;
	typedef logic [7:0] csl_data_t;

	// =============================================================
	// pin routings selected by route_sel
	typedef enum logic [1:0] {
		CSL_ROUTE_CMP_CMP = 2'b00,
		CSL_ROUTE_Q_CMP2 = 2'b01,
		CSL_ROUTE_CMP1_QN = 2'b10,
		CSL_ROUTE_Q_QN = 2'b11
	} csl_route_e;

endpackage : csl_pkg

// File: src/csl_sr_latch.sv
// unclocked reset-dominant set-reset latch cell
`timescale 1ns/1ps

module csl_sr_latch (
	input wire logic i_set,
	input wire logic i_rst,
	output logic o_q,
	output logic o_q_n
);
	import csl_pkg::*;

	// =============================================================
	// storage
	// level sensitive on purpose: the latch must follow comparator edges
	// that are far shorter than a clock period
	always_latch begin
		if (i_set || i_rst) begin
			o_q <= !i_rst;
		end
	end

	assign o_q_n = !o_q;

endmodule : csl_sr_latch

// File: src/csl_top.sv
// comparator set-reset latch: control register, latch and pin routing
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "csl_map.svh"

module csl_top (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire csl_pkg::csl_addr_t i_addr,
	input wire csl_pkg::csl_data_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output csl_pkg::csl_data_t o_rdata,
	input wire logic i_cmp1_result,
	input wire logic i_cmp2_result,
	input wire logic i_cmp1_pin_drive_enable,
	input wire logic i_cmp2_pin_drive_enable,
	input wire logic i_cmp1_port_direction,
	input wire logic i_cmp2_port_direction,
	output logic o_cmp1_pin,
	output logic o_cmp1_pin_oe,
	output logic o_cmp2_pin,
	output logic o_cmp2_pin_oe,
	output logic o_fixed_ref_enable
);
	import csl_pkg::*;

	// =============================================================
	// declarations
	csl_route_e route_sel_q;
	logic cmp1_set_enable_q;
	logic cmp2_reset_enable_q;
	logic set_pulse_q;
	logic reset_pulse_q;
	logic fixed_ref_enable_q;
	logic wr_ctrl;
	logic rd_ctrl;
	logic rd_stat;
	logic latch_set;
	logic latch_rst;
	logic latch_q;
	logic latch_q_n;
	logic [2:0] async_in;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] sync3_q;
	logic [2:0] stat_q;
	csl_data_t ctrl_view;
	csl_data_t stat_view;
	csl_data_t rdata_d;
	csl_data_t rdata_q;

	// =============================================================
	// address decode
	assign wr_ctrl = i_wr && (i_addr == `CSL_ADDR_LATCH_CONTROL);
	assign rd_ctrl = i_rd && (i_addr == `CSL_ADDR_LATCH_CONTROL);
	assign rd_stat = i_rd && (i_addr == `CSL_ADDR_LATCH_STATUS);

	// =============================================================
	// routing select
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			route_sel_q <= CSL_ROUTE_CMP_CMP;
		end else if (wr_ctrl) begin
			route_sel_q <= csl_route_e'({i_wdata[`CSL_BIT_ROUTE_SEL_HI],
				i_wdata[`CSL_BIT_ROUTE_SEL_LO]});
		end
	end

	// =============================================================
	// comparator path enables
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			cmp1_set_enable_q <= 1'b0;
			cmp2_reset_enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			cmp1_set_enable_q <= i_wdata[`CSL_BIT_CMP1_SET_ENABLE];
			cmp2_reset_enable_q <= i_wdata[`CSL_BIT_CMP2_RESET_ENABLE];
		end
	end

	// =============================================================
	// software pulse bits
	// a written one lives exactly one clock and then drops by itself;
	// a written zero never clears anything
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			set_pulse_q <= 1'b0;
			reset_pulse_q <= 1'b0;
		end else begin
			set_pulse_q <= wr_ctrl && i_wdata[`CSL_BIT_SET_PULSE];
			reset_pulse_q <= wr_ctrl && i_wdata[`CSL_BIT_RESET_PULSE];
		end
	end

	// =============================================================
	// reference enable, stored beside the latch controls
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			fixed_ref_enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			fixed_ref_enable_q <= i_wdata[`CSL_BIT_FIXED_REF_ENABLE];
		end
	end

	assign o_fixed_ref_enable = fixed_ref_enable_q;

	// =============================================================
	// latch inputs
	// system reset joins the reset term so the cell has a known state;
	// comparator inputs go in raw, the cell must catch short glitches
	assign latch_set = (i_cmp1_result && cmp1_set_enable_q)
		|| set_pulse_q;
	assign latch_rst = (i_cmp2_result && cmp2_reset_enable_q)
		|| reset_pulse_q || i_reset;

	csl_sr_latch u_latch (
		.i_set(latch_set),
		.i_rst(latch_rst),
		.o_q(latch_q),
		.o_q_n(latch_q_n)
	);

	// =============================================================
	// pin routing
	csl_pin_mux u_mux (
		.i_route_sel(route_sel_q),
		.i_cmp1_result(i_cmp1_result),
		.i_cmp2_result(i_cmp2_result),
		.i_latch_q(latch_q),
		.i_latch_q_n(latch_q_n),
		.i_cmp1_pin_drive_enable(i_cmp1_pin_drive_enable),
		.i_cmp2_pin_drive_enable(i_cmp2_pin_drive_enable),
		.i_cmp1_port_direction(i_cmp1_port_direction),
		.i_cmp2_port_direction(i_cmp2_port_direction),
		.o_cmp1_pin(o_cmp1_pin),
		.o_cmp1_pin_oe(o_cmp1_pin_oe),
		.o_cmp2_pin(o_cmp2_pin),
		.o_cmp2_pin_oe(o_cmp2_pin_oe)
	);

	// =============================================================
	// status synchronisers
	// status bits lag the live signals by four clocks, plus one for the read register
	assign async_in[`CSL_BIT_STAT_CMP1] = i_cmp1_result;
	assign async_in[`CSL_BIT_STAT_CMP2] = i_cmp2_result;
	assign async_in[`CSL_BIT_STAT_LATCH_Q] = latch_q;

	for (genvar g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge i_clk_sys) begin
			if (i_reset) begin
				sync1_q[g] <= 1'b0;
				sync2_q[g] <= 1'b0;
				sync3_q[g] <= 1'b0;
				stat_q[g] <= 1'b0;
			end else begin
				sync1_q[g] <= async_in[g];
				sync2_q[g] <= sync1_q[g];
				sync3_q[g] <= sync2_q[g];
				if (sync2_q[g] == sync3_q[g]) begin
					stat_q[g] <= sync3_q[g];
				end
			end
		end
	end

	// =============================================================
	// read data
	always_comb begin
		ctrl_view = `CSL_RST_LATCH_CONTROL;
		ctrl_view[`CSL_BIT_ROUTE_SEL_HI] = route_sel_q[1];
		ctrl_view[`CSL_BIT_ROUTE_SEL_LO] = route_sel_q[0];
		ctrl_view[`CSL_BIT_CMP1_SET_ENABLE] = cmp1_set_enable_q;
		ctrl_view[`CSL_BIT_CMP2_RESET_ENABLE] = cmp2_reset_enable_q;
		ctrl_view[`CSL_BIT_SET_PULSE] = set_pulse_q;
		ctrl_view[`CSL_BIT_RESET_PULSE] = reset_pulse_q;
		ctrl_view[`CSL_BIT_UNUSED] = 1'b0;
		ctrl_view[`CSL_BIT_FIXED_REF_ENABLE] = fixed_ref_enable_q;
	end

	always_comb begin
		stat_view = `CSL_RST_RDATA;
		stat_view[2:0] = stat_q;
	end

	always_comb begin
		rdata_d = `CSL_RST_RDATA;
		if (rd_ctrl) begin
			rdata_d = ctrl_view;
		end else if (rd_stat) begin
			rdata_d = stat_view;
		end
	end

	// unmapped reads and idle cycles return zero
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rdata_q <= `CSL_RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// =============================================================
	// assertions
	default clocking cb_sys @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	sequence s_write_set;
		wr_ctrl && i_wdata[`CSL_BIT_SET_PULSE];
	endsequence

	sequence s_write_rst;
		wr_ctrl && i_wdata[`CSL_BIT_RESET_PULSE];
	endsequence

	sequence s_quiet;
		!latch_set && !latch_rst;
	endsequence

	AST_SET_PULSE_ONE_CYCLE: assert property (
		s_write_set ##1 !(wr_ctrl && i_wdata[`CSL_BIT_SET_PULSE])
			|=> !set_pulse_q
	) else $error("set pulse did not clear after one cycle");

	AST_SET_PULSE_SETS_LATCH: assert property (
		s_write_set ##1 !latch_rst |-> latch_q ##1 latch_q || latch_rst
	) else $error("set pulse did not set the latch");

	AST_RST_PULSE_RESETS: assert property (
		s_write_rst |=> !latch_q
	) else $error("reset pulse did not reset the latch");

	AST_RESET_DOMINANT: assert property (
		(latch_set && latch_rst) |-> !latch_q
	) else $error("latch not reset when set and reset both high");

	AST_LATCH_HOLDS: assert property (
		s_quiet ##1 s_quiet |-> $stable(latch_q)
	) else $error("latch changed with no set or reset");

	AST_ZERO_WRITE_IGNORED: assert property (
		(wr_ctrl && !i_wdata[`CSL_BIT_SET_PULSE]
			&& !i_wdata[`CSL_BIT_RESET_PULSE]) |=> !set_pulse_q && !reset_pulse_q
	) else $error("pulse bit rose without a written one");

	AST_CMP1_GATED: assert property (
		(!cmp1_set_enable_q && !set_pulse_q) |-> !latch_set
	) else $error("comparator 1 set the latch while disabled");

	AST_CMP1_SETS: assert property (
		(i_cmp1_result && cmp1_set_enable_q && !latch_rst) |-> latch_q
	) else $error("enabled comparator 1 did not set the latch");

	AST_CMP2_RESETS: assert property (
		(i_cmp2_result && cmp2_reset_enable_q) |-> !latch_q
	) else $error("enabled comparator 2 did not reset the latch");

	AST_PIN2_ROUTE: assert property (
		route_sel_q[1] |-> (o_cmp2_pin == !latch_q)
	) else $error("pin 2 not inverted latch output");

	AST_PIN2_RAW: assert property (
		!route_sel_q[1] |-> (o_cmp2_pin == i_cmp2_result)
	) else $error("pin 2 not comparator 2 result");

	AST_PIN1_ROUTE: assert property (
		o_cmp1_pin == (route_sel_q[0] ? latch_q : i_cmp1_result)
	) else $error("pin 1 routing wrong");

	AST_ROUTE_WRITE: assert property (
		wr_ctrl |=> route_sel_q == $past(i_wdata[7:6])
	) else $error("routing select not taken from write");

	AST_DRIVE_ENABLE: assert property (
		o_cmp1_pin_oe == (i_cmp1_pin_drive_enable && !i_cmp1_port_direction)
		&& o_cmp2_pin_oe == (i_cmp2_pin_drive_enable && !i_cmp2_port_direction)
	) else $error("pin drive enable wrong");

	AST_UNUSED_BIT_ZERO: assert property (
		rd_ctrl |=> !o_rdata[`CSL_BIT_UNUSED]
			&& o_rdata[7:6] == $past(route_sel_q)
	) else $error("control read back wrong");

	AST_RESET_ROUTE: assert property (
		disable iff (1'b0) i_reset |=> route_sel_q == CSL_ROUTE_CMP_CMP
			&& !set_pulse_q && !reset_pulse_q
	) else $error("reset did not restore default routing");

	AST_ROUTE_INDEPENDENT: assert property (
		!wr_ctrl |=> $stable(route_sel_q) && $stable(cmp1_set_enable_q)
	) else $error("routing changed without a write");

endmodule : csl_top
